// ### afm_pkg.sv
/*
 * Constants, register map and carrier types for the alert flag and mask block.
 * Assumes a 32-bit classic Wishbone slave with one 8-bit register per aligned word.
 */
// Contract
// R01 - A vendor-specific alert event sets upper alert bit 7.
// R02 - A bus voltage fall through the sink disconnect threshold sets upper alert bit 3.
// R03 - An internal receive buffer overflow sets upper alert bit 2.
// R04 - Writing one to upper alert bit 2 only acknowledges it and keeps the overflow condition.
// R05 - The overflow condition clears only on a write of one to the lower receive status bit.
// R06 - Upper alert bit 1 is set while fault status AND fault enable has any bit set.
// R07 - A bus low-voltage alarm sets upper alert bit 0.
// R08 - The upper alert register resets to zero, reads back, and clears bits written with one.
// R09 - Each lower mask bit passes (one) or blocks (zero) the interrupt of its lower flag.
// R10 - Upper mask bits 7, 3, 2, 1, 0 gate their upper flags and bits 6 to 4 read zero.
// R11 - All three mask registers preset to all ones on reset, software reset and hard reset.
// R12 - Power state mask bits 7 to 0 gate the eight power state conditions in order.
// R13 - Software should normally leave lower mask bit 3, the hard reset interrupt, unmasked.
// R14 - The port power flag is high while power state AND power state mask has any bit set.
// R15 - Writing zero leaves a flag unchanged and the interrupt is high while a flag is unmasked.
`default_nettype none
package afm_pkg;
    localparam int AFM_DW = 8;
    localparam int AFM_AW = 8;

    // Register indices; byte address is four times the index
    localparam logic [AFM_AW-1:0] AFM_IDX_ALERT_LO = 8'h10;
    localparam logic [AFM_AW-1:0] AFM_IDX_ALERT_HI = 8'h11;
    localparam logic [AFM_AW-1:0] AFM_IDX_EN_LO = 8'h12;
    localparam logic [AFM_AW-1:0] AFM_IDX_EN_HI = 8'h13;
    localparam logic [AFM_AW-1:0] AFM_IDX_PWR_EN = 8'h14;
    localparam logic [AFM_AW-1:0] AFM_ADR_ALERT_LO = AFM_AW'(AFM_IDX_ALERT_LO * 4);
    localparam logic [AFM_AW-1:0] AFM_ADR_ALERT_HI = AFM_AW'(AFM_IDX_ALERT_HI * 4);
    localparam logic [AFM_AW-1:0] AFM_ADR_EN_LO = AFM_AW'(AFM_IDX_EN_LO * 4);
    localparam logic [AFM_AW-1:0] AFM_ADR_EN_HI = AFM_AW'(AFM_IDX_EN_HI * 4);
    localparam logic [AFM_AW-1:0] AFM_ADR_PWR_EN = AFM_AW'(AFM_IDX_PWR_EN * 4);

    // Upper alert bit positions
    localparam int AFM_BIT_VENDOR = 7;
    localparam int AFM_BIT_SNK_DISC = 3;
    localparam int AFM_BIT_RX_FULL = 2;
    localparam int AFM_BIT_FAULT = 1;
    localparam int AFM_BIT_LOW_ALARM = 0;
    // Lower alert receive status bit position
    localparam int AFM_BIT_RX_STATUS = 2;

    localparam logic [AFM_DW-1:0] AFM_FLAGS_RST = 8'h00;
    localparam logic [AFM_DW-1:0] AFM_EN_RST = 8'hff;
    localparam logic [AFM_DW-1:0] AFM_EN_HI_LIVE = 8'h8f;
    localparam logic [AFM_DW-1:0] AFM_ZERO = 8'h00;
    localparam logic [31:0] AFM_WORD_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic vendor_alert;     // Pulse: any vendor alert event
        logic snk_above;        // Level: bus above sink disconnect threshold
        logic rx_overflow;      // Pulse: internal receive buffer overflowed
        logic low_alarm;        // Pulse: bus low-voltage alarm
    } afm_events_t;

    typedef struct packed {
        logic [AFM_DW-1:0] fault_status;
        logic [AFM_DW-1:0] fault_enable;
        logic [AFM_DW-1:0] power_state;
        logic [AFM_DW-1:0] lower_alert_flags;
    } afm_status_t;
endpackage
`default_nettype wire

// ### afm_w1c_bank.sv
/*
 * Bank of sticky flags: hardware sets, software clears by writing one.
 * Assumes set and clear vectors are synchronous to clk_i; a set bit may be a pulse or a held level.
 */
`timescale 1ns/100ps
`default_nettype none
module afm_w1c_bank #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] flags_o
);
    import afm_pkg::*;

    wire [WIDTH-1:0] next_flags;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            // Set beats a clear in the same cycle so no event is lost
            assign next_flags[gi] = set_i[gi] | (flags_o[gi] & ~clr_i[gi]); // R15
        end
    endgenerate

    // One process owns the whole flag vector
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= RST_VAL;
        end else if (ce_i) begin
            flags_o <= next_flags;
        end
    end
endmodule
`default_nettype wire

// ### afm_alert_regs.sv
/*
 * Upper alert flags, lower/upper/power state masks and the interrupt output,
 * reached over a classic Wishbone slave (32-bit data, 8-bit registers in lane 0).
 * Assumes the lower alert, fault and power state registers live outside and
 * arrive as levels; event inputs other than snk_above are one-cycle pulses synchronous to clk_i.
 */
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module afm_alert_regs #(
    parameter int DW = afm_pkg::AFM_DW
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [afm_pkg::AFM_AW-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire afm_pkg::afm_events_t events_i,
    input wire afm_pkg::afm_status_t status_i,
    input wire logic software_reset_i,
    input wire logic hard_reset_rx_i,
    output logic irq_o,
    output logic port_power_flag_o,
    output logic rx_overflow_o,
    output logic [DW-1:0] lower_clear_o
);
    import afm_pkg::*;

    logic [DW-1:0] alert_flags_upper;
    logic [DW-1:0] alert_enable_lower;
    logic [DW-1:0] alert_enable_upper;
    logic [DW-1:0] power_state_enable;
    logic snk_above_q;
    logic rx_overflow;

    // Bus decode; the registered ack blocks a second strobe on the ack cycle
    wire access = cyc_i & stb_i & ~ack_o;
    wire wr_lane = access & we_i & sel_i[0];
    wire hit_lo = adr_i == AFM_ADR_ALERT_LO;
    wire hit_hi = adr_i == AFM_ADR_ALERT_HI;
    wire hit_en_lo = adr_i == AFM_ADR_EN_LO;
    wire hit_en_hi = adr_i == AFM_ADR_EN_HI;
    wire hit_pwr = adr_i == AFM_ADR_PWR_EN;
    wire [DW-1:0] wdata = dat_i[DW-1:0];

    wire [DW-1:0] upper_clr = (wr_lane & hit_hi) ? wdata : AFM_ZERO; // R08
    wire [DW-1:0] lower_clr = (wr_lane & hit_lo) ? wdata : AFM_ZERO;
    wire rx_status_write = lower_clr[AFM_BIT_RX_STATUS];

    // Event sources for the upper flags and the port power flag
    wire snk_fall = snk_above_q & ~events_i.snk_above; // R02
    wire fault_any = |(status_i.fault_status & status_i.fault_enable); // R06
    wire pwr_any = |(status_i.power_state & power_state_enable); // R12 R14

    logic [DW-1:0] upper_set;
    always_comb begin
        upper_set = AFM_ZERO;
        upper_set[AFM_BIT_VENDOR] = events_i.vendor_alert; // R01
        upper_set[AFM_BIT_SNK_DISC] = snk_fall; // R02
        upper_set[AFM_BIT_RX_FULL] = events_i.rx_overflow; // R03
        // Level source: re-asserts every cycle, so a clear only sticks once it drops
        upper_set[AFM_BIT_FAULT] = fault_any; // R06
        upper_set[AFM_BIT_LOW_ALARM] = events_i.low_alarm; // R07
    end

    afm_w1c_bank #(
        .WIDTH(DW),
        .RST_VAL(AFM_FLAGS_RST)
    ) u_upper_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .set_i(upper_set),
        .clr_i(upper_clr),
        .flags_o(alert_flags_upper)
    );

    // Overflow condition is separate from its flag: acking the flag leaves it standing
    wire next_rx_overflow = events_i.rx_overflow | (rx_overflow & ~rx_status_write); // R04 R05

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_overflow <= 1'b0;
            snk_above_q <= 1'b0;
        end else if (ce_i) begin
            rx_overflow <= next_rx_overflow;
            snk_above_q <= events_i.snk_above;
        end
    end

    // Masks preset on bus reset, software reset and received hard reset
    wire mask_preset = rst_i | software_reset_i | hard_reset_rx_i; // R11
    wire [DW-1:0] next_en_lo = (wr_lane & hit_en_lo) ? wdata : alert_enable_lower;
    wire [DW-1:0] next_en_hi = (wr_lane & hit_en_hi) ? wdata : alert_enable_upper;
    wire [DW-1:0] next_pwr_en = (wr_lane & hit_pwr) ? wdata : power_state_enable;

    always_ff @(posedge clk_i) begin
        if (mask_preset) begin
            alert_enable_lower <= AFM_EN_RST; // R11
            alert_enable_upper <= AFM_EN_RST;
            power_state_enable <= AFM_EN_RST;
        end else if (ce_i) begin
            alert_enable_lower <= next_en_lo;
            alert_enable_upper <= next_en_hi;
            power_state_enable <= next_pwr_en;
        end
    end

    // Reserved upper mask bits hold the last preset or written value internally but never read or gate
    wire [DW-1:0] en_hi_live = alert_enable_upper & AFM_EN_HI_LIVE; // R10
    wire upper_pend = |(alert_flags_upper & en_hi_live); // R10 R15
    wire lower_pend = |(status_i.lower_alert_flags & alert_enable_lower); // R09
    wire next_irq = upper_pend | lower_pend; // R15

    // Read mux; unmapped addresses read zero and ignore writes
    wire [DW-1:0] rd_byte =
        hit_lo ? status_i.lower_alert_flags :
        hit_hi ? alert_flags_upper :
        hit_en_lo ? alert_enable_lower :
        hit_en_hi ? en_hi_live :
        hit_pwr ? power_state_enable : AFM_ZERO;
    wire [31:0] next_dat = {{(32-DW){1'b0}}, rd_byte};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= AFM_WORD_ZERO;
            irq_o <= 1'b0;
            port_power_flag_o <= 1'b0;
            lower_clear_o <= AFM_ZERO;
        end else if (ce_i) begin
            ack_o <= access;
            dat_o <= access ? next_dat : dat_o;
            irq_o <= next_irq;
            port_power_flag_o <= pwr_any; // R14
            lower_clear_o <= lower_clr;
        end
    end

    assign rx_overflow_o = rx_overflow;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_vendor_sets_flag: assert property ( // R01
        ce_i && events_i.vendor_alert |=> alert_flags_upper[AFM_BIT_VENDOR])
        else $error("vendor alert did not set bit 7");

    chk_sink_fall_flag: assert property ( // R02
        ce_i && snk_above_q && !events_i.snk_above |=> alert_flags_upper[AFM_BIT_SNK_DISC])
        else $error("threshold fall did not set bit 3");

    chk_overflow_sets_both: assert property ( // R03
        ce_i && events_i.rx_overflow |=> alert_flags_upper[AFM_BIT_RX_FULL] && rx_overflow_o)
        else $error("overflow did not set flag and condition");

    chk_ack_keeps_overflow: assert property ( // R04
        ce_i && rx_overflow_o && upper_clr[AFM_BIT_RX_FULL] && !rx_status_write
        && !events_i.rx_overflow
        |=> rx_overflow_o && !alert_flags_upper[AFM_BIT_RX_FULL])
        else $error("flag acknowledge disturbed overflow condition");

    chk_rx_status_recovers: assert property ( // R05
        ce_i && rx_status_write && !events_i.rx_overflow |=> !rx_overflow_o)
        else $error("receive status write did not clear overflow");

    chk_fault_level_flag: assert property ( // R06
        ce_i && (|(status_i.fault_status & status_i.fault_enable))
        |=> alert_flags_upper[AFM_BIT_FAULT])
        else $error("fault summary not reflected in bit 1");

    chk_low_alarm_flag: assert property ( // R07
        ce_i && events_i.low_alarm |=> alert_flags_upper[AFM_BIT_LOW_ALARM])
        else $error("low alarm did not set bit 0");

    chk_write_one_clears: assert property ( // R08
        ce_i && upper_clr[AFM_BIT_LOW_ALARM] && !events_i.low_alarm
        |=> !alert_flags_upper[AFM_BIT_LOW_ALARM])
        else $error("write one did not clear bit 0");

    chk_write_zero_keeps: assert property ( // R15
        ce_i && wr_lane && hit_hi && !wdata[AFM_BIT_VENDOR] && alert_flags_upper[AFM_BIT_VENDOR]
        |=> alert_flags_upper[AFM_BIT_VENDOR])
        else $error("write zero changed a flag");

    chk_mask_preset_ones: assert property ( // R11
        software_reset_i || hard_reset_rx_i |=> alert_enable_lower == AFM_EN_RST
        && alert_enable_upper == AFM_EN_RST && power_state_enable == AFM_EN_RST)
        else $error("masks not preset to all ones");

    chk_irq_follows_pend: assert property ( // R09
        ce_i |=> irq_o == $past(|(alert_flags_upper & alert_enable_upper & AFM_EN_HI_LIVE)
        || |(status_i.lower_alert_flags & alert_enable_lower)))
        else $error("interrupt does not follow unmasked flags");

    chk_port_power_and: assert property ( // R14
        ce_i |=> port_power_flag_o == $past(|(status_i.power_state & power_state_enable)))
        else $error("port power flag wrong");

    chk_ack_one_cycle: assert property (
        ack_o && ce_i |=> !ack_o)
        else $error("ack held longer than one cycle");

    chk_reserved_read_zero: assert property ( // R10
        ce_i && access && !we_i && hit_en_hi |=> dat_o[6:4] == 3'h0)
        else $error("reserved mask bits read nonzero");
endmodule
`default_nettype wire

// ### tb_alert_flag_mask_registers.sv
/*
 * Self-checking bench for the alert flag and mask registers.
 * Assumes afm_pkg and the design files are compiled first; the bench is the bus master.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_alert_flag_mask_registers;
    import afm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sr = 1'b0, hr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, irq, ppf, rxo;
    logic [7:0] lclr;
    logic [3:0] ev = 4'h0;
    afm_status_t st = '0;
    int err_count = 0, num_checks = 0;

    always #5 clk_i = ~clk_i;

    afm_alert_regs afm_alert_regs_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .events_i(ev), .status_i(st), .software_reset_i(sr),
        .hard_reset_rx_i(hr), .irq_o(irq), .port_power_flag_o(ppf), .rx_overflow_o(rxo),
        .lower_clear_o(lclr));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Request stands until ack is seen high at a rising edge; data and release at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat[7:0];
        // A lost ack counts once and the run goes on to the closing report
        if (ack !== 1'b1) begin
            err_count++;
            $display("MISMATCH t=%0t no ack", $time);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask

    // Registered outputs lag one cycle; two falling edges leave margin
    task automatic idle;
        repeat (2) @(negedge clk_i);
    endtask

    task automatic pulse(input logic [3:0] p);
        @(posedge clk_i);
        ev <= ev | p;
        @(posedge clk_i);
        ev <= ev & ~p;
    endtask

    task automatic t_reset;
        rd(AFM_ADR_ALERT_HI, AFM_FLAGS_RST);
        rd(AFM_ADR_EN_LO, AFM_EN_RST);
        rd(AFM_ADR_EN_HI, 8'h8f);
        rd(AFM_ADR_PWR_EN, AFM_EN_RST);
        wr(8'h60, 8'hff);
        rd(8'h60, 8'h00);
        chk({7'h0, irq}, 8'h00);
    endtask

    task automatic t_events;
        logic [3:0] p[4];
        logic [7:0] e[4];
        p = '{4'h8, 4'h4, 4'h2, 4'h1};
        e = '{8'h80, 8'h08, 8'h04, 8'h01};
        for (int i = 0; i < 4; i++) begin
            pulse(p[i]);
            rd(AFM_ADR_ALERT_HI, e[i]);
            wr(AFM_ADR_ALERT_HI, 8'h00);
            rd(AFM_ADR_ALERT_HI, e[i]);
            wr(AFM_ADR_ALERT_HI, e[i]);
            rd(AFM_ADR_ALERT_HI, 8'h00);
        end
        chk({7'h0, rxo}, 8'h01);
        wr(AFM_ADR_ALERT_LO, 8'h04);
        chk(lclr, 8'h04);
        idle();
        chk({7'h0, rxo}, 8'h00);
        st.fault_status <= 8'h10;
        st.fault_enable <= 8'h01;
        rd(AFM_ADR_ALERT_HI, 8'h00);
        st.fault_enable <= 8'h11;
        rd(AFM_ADR_ALERT_HI, 8'h02);
        wr(AFM_ADR_ALERT_HI, 8'h02);
        rd(AFM_ADR_ALERT_HI, 8'h02);
        st.fault_status <= 8'h00;
        wr(AFM_ADR_ALERT_HI, 8'h02);
        rd(AFM_ADR_ALERT_HI, 8'h00);
    endtask

    task automatic t_irq;
        pulse(4'h8);
        idle();
        chk({7'h0, irq}, 8'h01);
        wr(AFM_ADR_EN_HI, 8'h7f);
        idle();
        chk({7'h0, irq}, 8'h00);
        rd(AFM_ADR_EN_HI, 8'h0f);
        wr(AFM_ADR_EN_HI, 8'h80);
        idle();
        chk({7'h0, irq}, 8'h01);
        wr(AFM_ADR_ALERT_HI, 8'h80);
        idle();
        chk({7'h0, irq}, 8'h00);
        wr(AFM_ADR_EN_HI, 8'hff);
        st.lower_alert_flags <= 8'h08;
        idle();
        chk({7'h0, irq}, 8'h01);
        wr(AFM_ADR_EN_LO, 8'hf7);
        idle();
        chk({7'h0, irq}, 8'h00);
        wr(AFM_ADR_EN_LO, 8'hff);
        st.lower_alert_flags <= 8'h00;
    endtask

    task automatic t_power;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            st.power_state <= 8'h01 << i;
            wr(AFM_ADR_PWR_EN, ~(8'h01 << i));
            idle();
            chk({7'h0, ppf}, 8'h00);
            wr(AFM_ADR_PWR_EN, 8'h01 << i);
            idle();
            chk({7'h0, ppf}, 8'h01);
        end
        st.power_state <= 8'h00;
    endtask

    task automatic t_presets;
        pulse(4'h8);
        for (int k = 0; k < 2; k++) begin
            wr(AFM_ADR_EN_LO, 8'h00);
            wr(AFM_ADR_EN_HI, 8'h00);
            wr(AFM_ADR_PWR_EN, 8'h00);
            @(posedge clk_i);
            if (k == 0) sr <= 1'b1;
            else hr <= 1'b1;
            @(posedge clk_i);
            sr <= 1'b0;
            hr <= 1'b0;
            rd(AFM_ADR_EN_LO, 8'hff);
            rd(AFM_ADR_EN_HI, 8'h8f);
            rd(AFM_ADR_PWR_EN, 8'hff);
            rd(AFM_ADR_ALERT_HI, 8'h80);
        end
    endtask

    // Low clock enable must drop events instead of latching them later
    task automatic t_freeze;
        wr(AFM_ADR_ALERT_HI, 8'h80);
        @(posedge clk_i);
        ce <= 1'b0;
        pulse(4'h8);
        idle();
        chk({7'h0, irq}, 8'h00);
        @(posedge clk_i);
        ce <= 1'b1;
        rd(AFM_ADR_ALERT_HI, 8'h00);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_events();
        t_irq();
        t_power();
        t_presets();
        t_freeze();
        report_and_stop();
    end
endmodule
`default_nettype wire
